// ===== rtl/fcmd_pkg.sv
// fcmd_pkg: constants, opcodes, field positions and types shared by the
// flash register command block and its word crossing.
// assumes: system clock of CLK_MHZ, serial link in SPI mode 0/3.
package fcmd_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ     = 200;
  localparam int WRR_TIME_US = 200;   // self-timed register write, plain value
  localparam int WRR_CYCLES  = WRR_TIME_US * CLK_MHZ;
  localparam int UNIQUE_ID_READ_DUMMY  = 32;    // dummy cycles, single or quad

  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_PT_READ  = 8'h5A;
  localparam logic [7:0] OP_UID_READ = 8'h4B;
  localparam logic [7:0] OP_SR1_READ = 8'h05;
  localparam logic [7:0] OP_SR2_READ = 8'h07;
  localparam logic [7:0] OP_CR1_READ = 8'h35;
  localparam logic [7:0] OP_CR2_READ = 8'h15;
  localparam logic [7:0] OP_CR3_READ = 8'h33;
  localparam logic [7:0] OP_REG_WR   = 8'h01;
  localparam logic [7:0] OP_WR_EN    = 8'h06;
  localparam logic [7:0] OP_WR_DIS   = 8'h04;
  localparam logic [7:0] OP_VWR_EN   = 8'h50;
  localparam logic [7:0] OP_CLR_STAT = 8'h30;
  localparam logic [7:0] OP_RST_EN   = 8'h66;
  localparam logic [7:0] OP_RST      = 8'h99;

  // ==========================================================================
  // field positions
  localparam int WIP_BIT  = 0;   // status 1
  localparam int WEL_BIT  = 1;   // status 1
  localparam int SRP_BIT  = 7;   // status 1, status_protect_bit
  localparam int PERR_BIT = 5;   // status 2
  localparam int EERR_BIT = 6;   // status 2
  localparam int QUAD_BIT = 1;   // config 1
  localparam int ADS_BIT  = 0;   // config 2, 4-byte address
  localparam int QPI_BIT  = 3;   // config 2, quad_command_mode
  localparam int LAT_MSB  = 3;   // config 3 read latency [3:0]

  // word layout {cr3, cr2, cr1, sr2, sr1} as seen by the link
  localparam int W_SR1 = 0;
  localparam int W_SR2 = 8;
  localparam int W_CR1 = 16;
  localparam int W_CR2 = 24;
  localparam int W_CR3 = 32;
  localparam int WORD_W = 40;

  // ==========================================================================
  // reset values, writable bytes packed {cr3, cr2, cr1, sr1}
  localparam logic [31:0] REGS_RST = 32'h0800_0000;   // latency 8
  localparam logic [39:0] WORD_RST = 40'h08_0000_0000;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    ST_OPC   = 3'b000,
    ST_ADDR  = 3'b001,
    ST_DUMMY = 3'b010,
    ST_OUT   = 3'b011,
    ST_DIN   = 3'b100,
    ST_IDLE  = 3'b101
  } fcmd_link_state_type;

  typedef enum logic [2:0] {
    SEL_PT  = 3'b000,
    SEL_UID = 3'b001,
    SEL_SR1 = 3'b010,
    SEL_SR2 = 3'b011,
    SEL_CR1 = 3'b100,
    SEL_CR2 = 3'b101,
    SEL_CR3 = 3'b110
  } fcmd_sel_type;

endpackage

// ===== rtl/fcmd_word_xfer.sv
// fcmd_word_xfer: carries a register word from the system clock to the
// serial clock by a toggle handshake.
// assumes: destination clock may stop; the word then simply goes stale.
`timescale 1ns/100ps
module fcmd_word_xfer #(
  parameter int              W        = 40,
  parameter logic [W-1:0]    RST_WORD = '0
) (
  // clocks and reset
  input  wire logic          clk_src_i,
  input  wire logic          clk_dst_i,
  input  wire logic          rst_n_i,
  // word
  input  wire logic [W-1:0]  word_i,
  output logic      [W-1:0]  word_o
);

  logic [W-1:0] hold;
  logic         req;
  logic         ack_s1;
  logic         ack_s2;
  logic         req_s1;
  logic         req_s2;
  logic         ack;

  // ==========================================================================
  // source side: reload the held word only once the last one was taken
  always_ff @(posedge clk_src_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold   <= RST_WORD;
      req    <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack;
      ack_s2 <= ack_s1;
      if (ack_s2 == req) begin
        hold <= word_i;
        req  <= ~req;
      end
    end
  end

  // ==========================================================================
  // destination side: hold is stable while req and ack differ
  always_ff @(posedge clk_dst_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      ack    <= 1'b0;
      word_o <= RST_WORD;
    end else begin
      req_s1 <= req;
      req_s2 <= req_s1;
      if (req_s2 != ack) begin
        word_o <= hold;
        ack    <= req_s2;
      end
    end
  end

endmodule

// ===== rtl/fcmd_core.sv
// fcmd_core: serial flash command handling for parameter-table read,
// unique-id read, register reads and the combined register write.
// assumes: host drives sck_i only while cs_n_i is low; cs_n_i stays high
// for at least four clock_i periods between frames.
// Operation
// - address length follows 4-byte address setting
// - dummy cycles from config 3 latency
// - table bytes out MSB first, falling edge
// - start at any address, sequential thereafter
// - quad mode moves opcode, data on four lines
// - unique id waits 32 dummy cycles
// - unique id is eight sequential bytes
// - status 1 readable anytime, refreshed per byte
// - status 2 readable anytime in single mode only, refreshed per byte
// - config 1-3 reads, repeated per byte
// - register write needs prior write enable
// - nonvolatile write copies into volatile registers
// - failed write sets error, stays busy
// - byte count at chip select rise
// - self-timed write, busy flag, latch cleared
// - resets ignored while register write runs
// - protect bit with pin low rejects writes
// - pin protection off in quad modes
// - status and error bit positions
`timescale 1ns/100ps
module fcmd_core
  import fcmd_pkg::*;
#(
  parameter int          WRR_CYC  = fcmd_pkg::WRR_CYCLES,
  parameter int          PT_BYTES = 16,
  parameter logic [8*PT_BYTES-1:0] PT_DATA = '0,   // table contents
  parameter logic [63:0] UID      = 64'h0123_4567_89AB_CDEF  // arbitrary
) (
  // system clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // serial link
  input  wire logic        sck_i,
  input  wire logic        cs_n_i,
  input  wire logic [3:0]  io_i,
  output logic      [3:0]  io_o,
  output logic      [3:0]  io_oe_o,
  // pins
  input  wire logic        wp_n_i,
  input  wire logic        hw_rst_n_i,
  // embedded write outcome: [0] erase fails, [1] program fails
  input  wire logic [1:0]  nv_fault_i,
  // register view
  output logic      [7:0]  status1_o,
  output logic      [7:0]  status2_o,
  output logic      [7:0]  config1_o,
  output logic      [7:0]  config2_o,
  output logic      [7:0]  config3_o
);
  import fcmd_pkg::*;

  localparam int PT_AW = $clog2(PT_BYTES);

  // ==========================================================================
  // functions
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [2:0]  nb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (i < nb) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] fetch(input fcmd_sel_type s,
                                       input logic [31:0]  p,
                                       input logic [39:0]  w);
    logic [7:0] b;
    case (s)
      SEL_PT:  b = PT_DATA[8*p[PT_AW-1:0] +: 8];
      SEL_UID: b = UID[8*(3'd7 - p[2:0]) +: 8];
      SEL_SR1: b = w[W_SR1 +: 8];
      SEL_SR2: b = w[W_SR2 +: 8];
      SEL_CR1: b = w[W_CR1 +: 8];
      SEL_CR2: b = w[W_CR2 +: 8];
      SEL_CR3: b = w[W_CR3 +: 8];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // ==========================================================================
  // link side: serial clock domain, sequencer and drivers cleared by chip select high
  fcmd_link_state_type st;
  fcmd_link_state_type next_st;
  fcmd_sel_type        sel;
  fcmd_sel_type        next_sel;
  logic [39:0]         lword;
  logic [7:0]          sh;
  logic [3:0]          bitc;
  logic [5:0]          cnt;
  logic [5:0]          next_cnt;
  logic [31:0]         addr;
  logic [31:0]         next_addr;
  logic [31:0]         ptr;
  logic [31:0]         next_ptr;
  logic [7:0]          out_sh;
  logic [7:0]          next_out;
  logic                load;
  logic                phase_end;
  logic [7:0]          f_op;
  logic                f_valid;
  logic [5:0]          f_bits;
  logic [31:0]         f_data;

  // chip select high holds the link logic in reset
  wire       link_rst_n = rst_n_i & ~cs_n_i;
  // quad command mode takes four bits per clock
  wire       qpi_l     = lword[W_CR2 + QPI_BIT];
  wire [3:0] step      = qpi_l ? 4'h4 : 4'h1;
  wire [7:0] sh_next   = qpi_l ? {sh[3:0], io_i} : {sh[6:0], io_i[0]};
  wire       byte_done = (bitc + step) == 4'h8;
  wire [5:0] addr_bits = lword[W_CR2 + ADS_BIT] ? 6'd32 : 6'd24;
  wire [31:0] addr_nx  = qpi_l ? {addr[27:0], io_i} : {addr[30:0], io_i[0]};
  // table latency, unique id fixed dummy count
  wire [5:0] lat       = {2'b00, lword[W_CR3 +: LAT_MSB + 1]};
  wire [5:0] dlen      = (sel == SEL_UID) ? 6'(UNIQUE_ID_READ_DUMMY) : lat;
  wire [7:0] out_shift = qpi_l ? {out_sh[3:0], 4'h0} : {out_sh[6:0], 1'b0};
  // MSB first on serial_out_io1, or the top nibble on all lines
  wire [3:0] drv_val   = qpi_l ? out_sh[7:4] : {2'b00, out_sh[7], 1'b0};
  wire [3:0] drv_en    = (st != ST_OUT) ? 4'h0 : (qpi_l ? 4'hF : 4'h2);

  // next state of the command sequencer
  always_comb begin
    next_st   = st;
    next_cnt  = cnt + 6'(step);
    next_addr = addr;
    next_ptr  = ptr;
    next_sel  = sel;
    next_out  = out_shift;
    load      = 1'b0;
    phase_end = 1'b0;
    case (st)
      ST_OPC: begin
        if (byte_done) begin
          phase_end = 1'b1;
          next_ptr  = 32'h0;
          next_st   = ST_OUT;
          load      = 1'b1;
          case (sh_next)
            OP_PT_READ: begin
              next_sel = SEL_PT;
              next_st  = ST_ADDR;
              load     = 1'b0;
            end
            // unique id goes to dummy phase first
            OP_UID_READ: begin
              next_sel = SEL_UID;
              next_st  = ST_DUMMY;
              load     = 1'b0;
            end
            // status 1 at any time, both modes
            OP_SR1_READ: next_sel = SEL_SR1;
            OP_SR2_READ: next_sel = SEL_SR2;
            OP_CR1_READ: next_sel = SEL_CR1;
            OP_CR2_READ: next_sel = SEL_CR2;
            OP_CR3_READ: next_sel = SEL_CR3;
            OP_REG_WR: begin
              next_st = ST_DIN;
              load    = 1'b0;
            end
            default: begin
              next_st = ST_IDLE;
              load    = 1'b0;
            end
          endcase
          // quad mode refuses these register reads; only status 1 is answered
          if (qpi_l && load && next_sel != SEL_SR1) begin
            next_st = ST_IDLE;
            load    = 1'b0;
          end
        end
      end
      ST_ADDR: begin
        next_addr = addr_nx;
        if (next_cnt == addr_bits) begin
          // random start from the supplied address
          next_ptr  = addr_nx;
          phase_end = 1'b1;
          next_st   = (lat == 6'h0) ? ST_OUT : ST_DUMMY;
          load      = (lat == 6'h0);
        end
      end
      ST_DUMMY: begin
        next_cnt = cnt + 6'h1;
        if (next_cnt == dlen) begin
          phase_end = 1'b1;
          next_st   = ST_OUT;
          load      = 1'b1;
        end
      end
      ST_OUT: begin
        if (byte_done) begin
          next_ptr = ptr + 32'h1;
          load     = 1'b1;
        end
      end
      default: next_st = st;
    endcase
    if (load) begin
      next_out = fetch(next_sel, next_ptr, lword);
    end
  end

  // sequencer registers
  always_ff @(posedge sck_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      st     <= ST_OPC;
      sel    <= SEL_SR1;
      sh     <= 8'h00;
      bitc   <= 4'h0;
      cnt    <= 6'h0;
      addr   <= 32'h0;
      ptr    <= 32'h0;
      out_sh <= 8'h00;
    end else begin
      st     <= next_st;
      sel    <= next_sel;
      sh     <= sh_next;
      bitc   <= (byte_done || phase_end) ? 4'h0 : bitc + step;
      cnt    <= phase_end ? 6'h0 : next_cnt;
      addr   <= next_addr;
      ptr    <= next_ptr;
      out_sh <= next_out;
    end
  end

  // data changes on the falling edge; lines released at once
  always_ff @(negedge sck_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      io_o    <= 4'h0;
      io_oe_o <= 4'h0;
    end else begin
      io_o    <= drv_val;
      io_oe_o <= drv_en;
    end
  end

  // frame record: survives chip select so the system side can read it
  // data bits are counted, bytes land in order sr1, cr1, cr2, cr3
  always_ff @(posedge sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      f_op    <= 8'h00;
      f_valid <= 1'b0;
      f_bits  <= 6'h0;
      f_data  <= 32'h0;
    end else if (st == ST_OPC) begin
      f_valid <= byte_done;
      f_op    <= sh_next;
      f_bits  <= 6'h0;
    end else if (st == ST_DIN && f_bits < 6'd33) begin
      f_bits <= f_bits + 6'(step);
      if (byte_done && f_bits < 6'd32) begin
        f_data[8*f_bits[4:3] +: 8] <= sh_next;
      end
    end
  end

  // ==========================================================================
  // system side
  logic        cs_s1;
  logic        cs_s2;
  logic        cs_s3;
  logic        wp_s1;
  logic        wp_s2;
  logic        hr_s1;
  logic        hr_s2;
  logic [31:0] vreg;    // {config3_volatile, config2_volatile, config1_volatile, status1_volatile}, low two bits unused
  logic [31:0] nreg;    // non-volatile copies, same layout
  logic        write_in_progress;
  logic        write_enable_latch;
  logic        perr;
  logic        eerr;
  logic        vol_arm;
  logic        rst_en;
  logic [2:0]  pend_n;
  logic [31:0] pend_data;
  logic [31:0] timer;

  // pins through two flops each, chip select through three for the edge
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
      hr_s1 <= 1'b1;
      hr_s2 <= 1'b1;
    end else begin
      cs_s1 <= cs_n_i;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      wp_s1 <= wp_n_i;
      wp_s2 <= wp_s1;
      hr_s1 <= hw_rst_n_i;
      hr_s2 <= hr_s1;
    end
  end

  // frame decode at chip select rise; single-byte commands need no data
  wire       fe       = cs_s2 & ~cs_s3 & f_valid;
  wire       single   = fe & (f_bits == 6'h0);
  wire       op_write_enable_cmd  = single & (f_op == OP_WR_EN);
  wire       op_wrdi  = single & (f_op == OP_WR_DIS);
  wire       op_vwren = single & (f_op == OP_VWR_EN);
  wire       op_clear_status_cmd  = single & (f_op == OP_CLR_STAT);
  wire       op_rsten = single & (f_op == OP_RST_EN);
  wire       op_rst   = single & (f_op == OP_RST) & rst_en;
  // only whole counts of one to four bytes are taken
  wire [2:0] nb       = (f_bits[2:0] != 3'h0 || f_bits > 6'd32) ? 3'h0
                        : f_bits[5:3];
  // pin protection only when neither quad mode is on
  wire       quad_any = vreg[8 + QUAD_BIT] | vreg[16 + QPI_BIT];
  wire       locked   = vreg[SRP_BIT] & ~wp_s2 & ~quad_any;
  // write enable or volatile write enable must precede
  wire       wrr_ok   = fe & (f_op == OP_REG_WR) & ~write_in_progress & (nb != 3'h0)
                        & (write_enable_latch | vol_arm) & ~locked;
  wire       wr_vol   = wrr_ok & vol_arm;
  wire       wr_nv    = wrr_ok & ~vol_arm;
  // resets held off while the write runs
  wire       do_reset = (~hr_s2 | op_rst) & ~write_in_progress;
  wire       done     = write_in_progress & (timer == 32'h1);
  wire       fail     = done & (nv_fault_i != 2'b00);
  wire [31:0] nreg_new = merge(nreg, pend_data, pend_n);

  // volatile registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vreg <= REGS_RST;
    end else if (do_reset) begin
      vreg <= nreg;
    end else if (wr_vol) begin
      // volatile target leaves the copies alone
      vreg <= merge(vreg, f_data, nb);
    end else if (done && !fail) begin
      // new non-volatile values copied into the volatile set
      vreg <= nreg_new;
    end
  end

  // non-volatile copies, written only at the end of a good cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nreg <= REGS_RST;
    end else if (done && !fail) begin
      // erase and program as one step
      nreg <= nreg_new;
    end
  end

  // self-timed cycle starts at chip select rise
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer     <= 32'h0;
      pend_n    <= 3'h0;
      pend_data <= 32'h0;
    end else if (wr_nv) begin
      timer     <= 32'(WRR_CYC);
      pend_n    <= nb;
      pend_data <= f_data;
    end else if (timer != 32'h0) begin
      timer <= timer - 32'h1;
    end
  end

  // status flags; a starting write wins over any clear in the same cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      write_in_progress     <= 1'b0;
      write_enable_latch     <= 1'b0;
      perr    <= 1'b0;
      eerr    <= 1'b0;
      vol_arm <= 1'b0;
      rst_en  <= 1'b0;
    end else begin
      // busy through the cycle; stays busy on failure
      if (wr_nv) begin
        write_in_progress <= 1'b1;
      end else if (op_clear_status_cmd || (done && !fail)) begin
        write_in_progress <= 1'b0;
      end
      // latch set by write enable; cleared on completion
      if (op_write_enable_cmd && !write_in_progress) begin
        write_enable_latch <= 1'b1;
      end else if (op_clear_status_cmd || (done && !fail) || do_reset
                   || (op_wrdi && !write_in_progress)) begin
        write_enable_latch <= 1'b0;
      end
      if (fail) begin
        perr <= nv_fault_i[1];
        eerr <= nv_fault_i[0];
      end else if (op_clear_status_cmd) begin
        perr <= 1'b0;
        eerr <= 1'b0;
      end
      // volatile target lasts only until the next command
      if (fe) begin
        vol_arm <= op_vwren;
        rst_en  <= op_rsten;
      end
    end
  end

  // ==========================================================================
  // register view out, and the same word to the link side
  // busy at bit 0, latch at bit 1, errors at 5 and 6
  wire [7:0]  sr1_w = {vreg[7:2], write_enable_latch, write_in_progress};
  wire [7:0]  sr2_w = {1'b0, eerr, perr, 5'b00000};
  wire [39:0] sword = {vreg[31:8], sr2_w, sr1_w};

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status1_o <= REGS_RST[7:0];
      status2_o <= 8'h00;
      config1_o <= REGS_RST[15:8];
      config2_o <= REGS_RST[23:16];
      config3_o <= REGS_RST[31:24];
    end else begin
      status1_o <= sr1_w;
      status2_o <= sr2_w;
      config1_o <= vreg[15:8];
      config2_o <= vreg[23:16];
      config3_o <= vreg[31:24];
    end
  end

  // refreshed value for status reads; stale by a few serial clocks
  fcmd_word_xfer #(
    .W        (WORD_W),
    .RST_WORD (WORD_RST)
  ) u_xfer (
    .clk_src_i (clock_i),
    .clk_dst_i (sck_i),
    .rst_n_i   (rst_n_i),
    .word_i    (sword),
    .word_o    (lword)
  );

endmodule

// ===== sim/fcmd_core_asserts.sv
// fcmd_core_chk: port-level checks on the flash register command block.
// assumes: bound into fcmd_core, one clock domain at clock_i.
`timescale 1ns/100ps
module fcmd_core_chk
  import fcmd_pkg::*;
#(
  parameter int WRR_CYC = 20
) (
  // clock and reset
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  // link and pins
  input wire logic       cs_n_i,
  input wire logic [3:0] io_oe_o,
  input wire logic       wp_n_i,
  // register view
  input wire logic [7:0] status1_o,
  input wire logic [7:0] status2_o,
  input wire logic [7:0] config1_o,
  input wire logic [7:0] config2_o,
  input wire logic [7:0] config3_o
);
  // ==========
  // busy length, zero outside a write so a stuck flag shows up
  int unsigned bc;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) bc <= 0;
    else bc <= status1_o[WIP_BIT] ? bc + 1 : 0;
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  // ==========
  // checks
  chk_oe_idle: assert property (
    cs_n_i && $past(cs_n_i) |-> io_oe_o == 4'h0)
    else $error("output enabled while deselected");
  chk_oe_single: assert property (
    io_oe_o != 4'h0 && !config2_o[QPI_BIT] |-> io_oe_o == 4'h2)
    else $error("single mode drives wrong lines");
  chk_busy_min: assert property (
    $fell(status1_o[WIP_BIT]) |-> bc >= WRR_CYC - 2)
    else $error("register write ended early");
  chk_busy_max: assert property (
    status1_o[WIP_BIT] && status2_o[6:5] == 2'h0 |-> bc <= WRR_CYC + 4)
    else $error("register write runs too long");
  chk_err_busy: assert property (
    status2_o[PERR_BIT] || status2_o[EERR_BIT] |-> status1_o[WIP_BIT])
    else $error("error flag without busy");
  chk_wel_done: assert property (
    $fell(status1_o[WIP_BIT]) |-> !status1_o[WEL_BIT])
    else $error("latch left set after write");
  chk_rst_busy: assert property (
    status1_o[WIP_BIT] && status1_o[WEL_BIT]
    |=> status1_o[WEL_BIT] || !status1_o[WIP_BIT])
    else $error("latch lost during write");
  chk_protect: assert property (
    status1_o[SRP_BIT] && !config1_o[QUAD_BIT] && !config2_o[QPI_BIT]
    && !wp_n_i && !$past(wp_n_i, 1) && !$past(wp_n_i, 2)
    && !$past(wp_n_i, 3) |=> $stable(config3_o) && $stable(config1_o))
    else $error("protected register changed");
  chk_err_layout: assert property (
    $rose(status2_o[PERR_BIT]) |-> status2_o[7] == 1'h0
    && status2_o[4:0] == 5'h00 && status1_o[WIP_BIT])
    else $error("status 2 layout wrong");
endmodule
bind fcmd_core fcmd_core_chk #(.WRR_CYC(WRR_CYC)) u_fcmd_core_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
  .io_oe_o(io_oe_o), .wp_n_i(wp_n_i), .status1_o(status1_o),
  .status2_o(status2_o), .config1_o(config1_o),
  .config2_o(config2_o), .config3_o(config3_o));

// ===== sim/fcmd_host.sv
// fcmd_host: behavioural SPI host, single line, mode 0.
// assumes: device answers on io line 1 after falling sck edges.
`timescale 1ns/100ps
module fcmd_host (
  // link out
  output logic            sck_o,
  output logic            cs_n_o,
  output logic [3:0]      io_o,
  // link in
  input  wire logic [3:0] io_i
);
  // ==========
  // idle: clock still, unused lines toggle so stale data never passes
  initial begin
    sck_o = 1'h0;
    cs_n_o = 1'h1;
    io_o = 4'h5;
  end
  // 48 ns clock, below both rate limits
  task automatic frame(input logic [71:0] tx, input int nt,
                       input int nr, output logic [63:0] rx);
    rx = '0;
    #7.3 cs_n_o = 1'h0;
    for (int i = 0; i < nt + nr; i++) begin
      io_o = {~io_o[3:1], (i < nt) ? tx[71-i] : ~io_o[0]};
      #24 sck_o = 1'h1;
      if (i >= nt) rx = {rx[62:0], io_i[1]};
      #24 sck_o = 1'h0;
    end
    #24 cs_n_o = 1'h1;
    #50;
  endtask
endmodule

// ===== sim/fcmd_core_tb.sv
// fcmd_core_tb: self-checking bench for the flash register commands.
// assumes: host model drives the link, pins move at clock_i edges.
`timescale 1ns/100ps
module fcmd_core_tb;
  import fcmd_pkg::*;
  localparam int          WC   = 400;
  localparam logic [63:0] UIDV = 64'h5A3C_96E1_0F7B_2D48; // arbitrary
  logic            clock_i = 1'h0;
  logic            rst_n_i = 1'h0;
  logic            wp_n    = 1'h1;
  logic            hwr_n   = 1'h1;
  logic [1:0]      flt     = 2'h0;
  logic            sck;
  logic            cs_n;
  logic [3:0]      hio;
  logic [3:0]      dio;
  logic [3:0]      doe;
  logic [7:0]      s1, s2, c1, c2, c3;
  logic [63:0]     rx;
  int              n_fail = 0;
  int              check_count = 0;
  // ==========
  // shared wire: device wins where it drives
  wire logic [3:0] line = (doe & dio) | (~doe & hio);
  always #2.5 clock_i = ~clock_i;
  fcmd_core #(.WRR_CYC(WC), .UID(UIDV),
    .PT_DATA(128'h0F0E0D0C0B0A09080706050403020100)) u_fcmd_core (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .sck_i(sck), .cs_n_i(cs_n),
    .io_i(line), .io_o(dio), .io_oe_o(doe), .wp_n_i(wp_n),
    .hw_rst_n_i(hwr_n), .nv_fault_i(flt), .status1_o(s1),
    .status2_o(s2), .config1_o(c1), .config2_o(c2), .config3_o(c3));
  fcmd_host u_fcmd_host (.sck_o(sck), .cs_n_o(cs_n), .io_o(hio),
    .io_i(line));
  // ==========
  // helpers
  task automatic cmp(input string n, input logic [63:0] e, g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic x(input logic [71:0] t, input int nt, input int nr);
    u_fcmd_host.frame(t, nt, nr, rx);
  endtask
  // enable frame, write frame, then a throwaway frame to settle
  // written words keep reserved bits zero
  task automatic wr(input logic [7:0] en, input logic [31:0] d,
                    input int nb);
    x({en, 64'h0}, 8, 0);
    x({8'h01, d, 32'h0}, 8 + nb, 0);
    w(4);
    x({8'hFF, 64'h0}, 8, 0);
  endtask
  task automatic rd(input logic [7:0] op, input logic [7:0] v);
    x({op, 64'h0}, 8, 16);
    cmp("read", {v, v}, rx[15:0]);
  endtask
  task automatic t_vol();
    wr(8'h50, 32'h1C00_0005, 32);
    cmp("regs", 40'h1C_0000_0500, {s1, c1, c2, c3, s2});
    rd(8'h05, 8'h1C);
    // register reads kept to single-line mode
    rd(8'h35, 8'h00);
    rd(8'h15, 8'h00);
    rd(8'h33, 8'h05);
  endtask
  task automatic t_cnt();
    wr(8'h50, 32'h2440_0000, 12);
    x({8'h01, 64'h2400_0000_0000_0000}, 16, 0);
    cmp("cancel", 32'h1C00_0005, {s1, c1, c2, c3});
    wr(8'h50, 32'h2040_0000, 8);
    cmp("one", 32'h2000_0005, {s1, c1, c2, c3});
  endtask
  task automatic t_rd();
    x({8'h5A, 24'h000003, 40'h0}, 37, 16);
    cmp("table", 16'h0304, rx[15:0]);
    x({8'h4B, 64'h0}, 40, 64);
    cmp("uid", UIDV, rx);
    wr(8'h50, 32'h2000_0105, 32);
    x({8'h5A, 32'h0000_000E, 32'h0}, 45, 16);
    cmp("table4", 16'h0E0F, rx[15:0]);
  endtask
  task automatic t_prot();
    wr(8'h50, 32'h8002_0006, 32);
    @(posedge clock_i) wp_n <= 1'h0;
    w(4);
    wr(8'h50, 32'h8000_0003, 32);
    cmp("quad", 16'h0003, {c1, c3});
    wr(8'h50, 32'h8000_0007, 32);
    cmp("prot", 8'h03, c3);
    @(posedge clock_i) wp_n <= 1'h1;
    w(4);
    wr(8'h50, 32'h0000_0005, 32);
    cmp("open", 16'h0005, {s1, c3});
  endtask
  task automatic t_nv();
    wr(8'h06, 32'h0040_0000, 16);
    cmp("busy", 2'h3, s1[1:0]);
    @(posedge clock_i) hwr_n <= 1'h0;
    w(4);
    hwr_n <= 1'h1;
    for (int i = 0; i < 1000 && s1[0] !== 1'h0; i++) w(1);
    cmp("nv", 16'h0040, {s1, c1});
  endtask
  task automatic t_fail();
    @(posedge clock_i) flt <= 2'h2;
    wr(8'h06, 32'h0, 8);
    for (int i = 0; i < 1000 && s2[5] !== 1'h1; i++) w(1);
    cmp("err", 9'h120, {s1[0], s2});
    rd(8'h07, 8'h20);
    @(posedge clock_i) flt <= 2'h0;
    x({8'h30, 64'h0}, 8, 0);
    w(4);
    cmp("clear", 10'h000, {s1[1:0], s2});
  endtask
  task automatic conclude();
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========
  // main sequence and watchdog
  initial begin
    w(10);
    rst_n_i <= 1'h1;
    w(4);
    cmp("reset", 40'h00_0000_0008, {s1, s2, c1, c2, c3});
    t_vol();
    t_cnt();
    t_rd();
    t_prot();
    t_nv();
    t_fail();
    conclude();
  end
  initial begin
    #300000;
    n_fail++;
    conclude();
  end
endmodule
